// file: hw/bcx_cmp.sv
// Subtract-and-discard unit producing the compare flags
`timescale 1ns/1ps
`include "bcx_defs.svh"
module bcx_cmp (
   // Operands
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic use_carry,
   input wire logic [7:0] flags_in,
   // Result flags
   output logic [7:0] flags_out
);
   logic [8:0] diff;
   logic [7:0] r;
   logic cin;

   always_comb
   begin
      cin = use_carry & flags_in[`BCX_FLAG_C];
      diff = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      r = diff[7:0];
      flags_out = flags_in;
      flags_out[`BCX_FLAG_C] = diff[8];
      flags_out[`BCX_FLAG_N] = r[7];
      flags_out[`BCX_FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      flags_out[`BCX_FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      // With carry the zero flag can only be kept or cleared, so multi-byte compares chain
      flags_out[`BCX_FLAG_Z] = (r == 8'h00) & (~use_carry | flags_in[`BCX_FLAG_Z]);
   end
endmodule // bcx_cmp

// file: hw/bcx_dec_if.sv
// Decoded instruction fields passed from the decoder to the execution unit
`timescale 1ns/1ps
interface bcx_dec_if;
   import bcx_pkg::*;
   logic [15:0] instr;
   logic [15:0] next_instr;
   bcx_op_t op;
   logic [4:0] rd;
   logic [4:0] rr;
   logic [7:0] imm;
   logic [2:0] bsel;
   logic [15:0] off;
   logic two_word;
   modport dec (input instr, input next_instr, output op, output rd, output rr,
      output imm, output bsel, output off, output two_word);
   modport exe (output instr, output next_instr, input op, input rd, input rr,
      input imm, input bsel, input off, input two_word);
endinterface

// file: hw/bcx_decode.sv
// Instruction decoder for control-flow and compare instructions
`timescale 1ns/1ps
`include "bcx_defs.svh"
module bcx_decode (
   // Decoded fields
   bcx_dec_if.dec d
);
   import bcx_pkg::*;

   function automatic logic hit(input logic [15:0] w, input logic [15:0] m,
      input logic [15:0] p);
      hit = ((w & m) == p);
   endfunction

   always_comb
   begin
      d.op = bcx_other_op;
      if (hit(d.instr, `BCX_M_REL, `BCX_P_RELATIVE_JUMP_OP)) d.op = bcx_relative_jump_op;
      else if (hit(d.instr, `BCX_M_REL, `BCX_P_RELATIVE_CALL_OP)) d.op = bcx_relative_call_op;
      else if (hit(d.instr, `BCX_M_FULL, `BCX_P_POINTER_JUMP_OP)) d.op = bcx_pointer_jump_op;
      else if (hit(d.instr, `BCX_M_FULL, `BCX_P_POINTER_CALL_OP)) d.op = bcx_pointer_call_op;
      else if (hit(d.instr, `BCX_M_FULL, `BCX_P_SUBRET)) d.op = bcx_subroutine_return_op;
      else if (hit(d.instr, `BCX_M_FULL, `BCX_P_IRQRET)) d.op = bcx_interrupt_return_op;
      else if (hit(d.instr, `BCX_M_RR, `BCX_P_COMPARE_SKIP_EQUAL_OP)) d.op = bcx_compare_skip_equal_op;
      else if (hit(d.instr, `BCX_M_RR, `BCX_P_CMP)) d.op = bcx_register_compare_op;
      else if (hit(d.instr, `BCX_M_RR, `BCX_P_CMPC)) d.op = bcx_compare_with_carry_op;
      else if (hit(d.instr, `BCX_M_REL, `BCX_P_CMPI)) d.op = bcx_compare_immediate_op;
      else if (hit(d.instr, `BCX_M_SKB, `BCX_P_SKBC)) d.op = bcx_skip_reg_bit_clear_op;
      else if (hit(d.instr, `BCX_M_SKB, `BCX_P_SKBS)) d.op = bcx_skip_reg_bit_set_op;
      else if (hit(d.instr, `BCX_M_BRB, `BCX_P_BRANCH_STATUS_BIT_SET_OP)) d.op = bcx_branch_status_bit_set_op;
      else if (hit(d.instr, `BCX_M_BRB, `BCX_P_BRANCH_STATUS_BIT_CLEAR_OP)) d.op = bcx_branch_status_bit_clear_op;
   end

   // Immediate compare reaches only the upper sixteen registers
   assign d.rd = (d.op == bcx_compare_immediate_op) ? {1'b1, d.instr[7:4]} : d.instr[8:4];
   assign d.rr = (d.op == bcx_skip_reg_bit_clear_op || d.op == bcx_skip_reg_bit_set_op) ?
      d.instr[8:4] : {d.instr[9], d.instr[3:0]};
   assign d.imm = {d.instr[11:8], d.instr[3:0]};
   assign d.bsel = d.instr[2:0];
   assign d.off = (d.op == bcx_branch_status_bit_set_op ||
      d.op == bcx_branch_status_bit_clear_op) ?
      {{9{d.instr[9]}}, d.instr[9:3]} : {{4{d.instr[11]}}, d.instr[11:0]};
   assign d.two_word = hit(d.next_instr, `BCX_M_LDS, `BCX_P_LDS) ||
      hit(d.next_instr, `BCX_M_JMP, `BCX_P_JMP);
endmodule // bcx_decode

// file: hw/bcx_defs.svh
// Constants of the branch/compare execution unit: offsets, fields, resets, cycle counts
`ifndef BCX_DEFS_SVH
`define BCX_DEFS_SVH

// Register byte offsets on the AHB-Lite slave
`define BCX_REG_CTRL 8'h00
`define BCX_REG_PROG 8'h04
`define BCX_REG_STATE 8'h08
`define BCX_REG_COUNT 8'h0C
`define BCX_CTRL_RUN_BIT 0
`define BCX_CTRL_RST 1'h1

// Status register bit positions
`define BCX_FLAG_C 0
`define BCX_FLAG_Z 1
`define BCX_FLAG_N 2
`define BCX_FLAG_V 3
`define BCX_FLAG_H 5
`define BCX_FLAG_I 7

// Cycle counts minus one, as loaded into the busy counter
`define BCX_CYC2_M1 2'h1
`define BCX_CYC3_M1 2'h2
`define BCX_CYC4_M1 2'h3

// Opcode masks and patterns
`define BCX_M_REL 16'hF000
`define BCX_P_RELATIVE_JUMP_OP 16'hC000
`define BCX_P_RELATIVE_CALL_OP 16'hD000
`define BCX_M_FULL 16'hFFFF
`define BCX_P_POINTER_JUMP_OP 16'h9409
`define BCX_P_POINTER_CALL_OP 16'h9509
`define BCX_P_SUBRET 16'h9508
`define BCX_P_IRQRET 16'h9518
`define BCX_M_RR 16'hFC00
`define BCX_P_COMPARE_SKIP_EQUAL_OP 16'h1000
`define BCX_P_CMP 16'h1400
`define BCX_P_CMPC 16'h0400
`define BCX_P_CMPI 16'h3000
`define BCX_M_SKB 16'hFE08
`define BCX_P_SKBC 16'hFC00
`define BCX_P_SKBS 16'hFE00
`define BCX_M_BRB 16'hFC00
`define BCX_P_BRANCH_STATUS_BIT_SET_OP 16'hF000
`define BCX_P_BRANCH_STATUS_BIT_CLEAR_OP 16'hF400
// Two-word instruction patterns (direct load/store, long jump/call)
`define BCX_M_LDS 16'hFC0F
`define BCX_P_LDS 16'h9000
`define BCX_M_JMP 16'hFE0C
`define BCX_P_JMP 16'h940C

`endif

// file: hw/bcx_exec_unit.sv
// Execution unit for jumps, calls, returns, compares, skips and status branches
//
// How it works
// - Relative jump: target offset plus one, two cycles
// - Pointer jump loads pointer pair, two cycles
// - Relative call: offset plus one, three cycles
// - Pointer call loads pointer pair, three cycles
// - Subroutine return pops address, four cycles
// - Equal registers skip next; one to three cycles
// - Register compare sets five flags, one cycle
// - Compare with carry subtracts carry too
// - Immediate compare sets five flags, one cycle
// - Skip when register bit is zero
// - Skip when register bit is one
// - Branch when status bit set; one/two cycles
// - Branch when status bit clear; one/two cycles
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "bcx_defs.svh"
module bcx_exec_unit #(
   parameter int PC_W = 16
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Instruction fetch
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire logic [15:0] next_instr,
   output logic instr_ready,
   output logic [PC_W-1:0] program_counter,
   // Register file and status register
   output logic [4:0] rd_addr,
   output logic [4:0] rr_addr,
   input wire logic [7:0] rd_data,
   input wire logic [7:0] rr_data,
   input wire logic [7:0] status_in,
   input wire logic [PC_W-1:0] zptr,
   output logic flags_we,
   output logic [7:0] flags_out,
   output bcx_pkg::bcx_op_t last_op,
   // Stack
   output logic push_valid,
   output logic [PC_W-1:0] push_data,
   output logic pop_req,
   input wire logic [PC_W-1:0] stack_data
);
   import bcx_pkg::*;

   if (PC_W < 8 || PC_W > 16)
   begin : g_chk
      $error("PC_W must lie between 8 and 16");
   end

   typedef struct packed {
      bcx_state_t st;
      logic [1:0] cnt;
      logic [PC_W-1:0] prog;
      logic [PC_W-1:0] tgt;
      logic pop_req;
      logic pop_wait;
      logic push_v;
      logic [PC_W-1:0] push_d;
      logic flg_we;
      logic [7:0] flg;
      logic run;
      bcx_op_t last_op;
      logic [15:0] nops;
      logic hr_sel;
      logic hr_wr;
      logic [7:0] hr_addr;
      logic [31:0] hrdata;
   } bcx_regs_t;

   bcx_regs_t q_ff;
   bcx_regs_t nxt_q;

   bcx_dec_if dif ();
   logic [7:0] cmp_a;
   logic [7:0] cmp_b;
   logic cmp_use_c;
   logic [7:0] cmp_flags;
   logic accept;
   logic [PC_W-1:0] addr_plus1;
   logic [PC_W-1:0] rel_tgt;
   logic [PC_W-1:0] skip_tgt;
   logic [1:0] skip_m1;
   logic reg_bit;
   logic stat_bit;

   assign dif.instr = instr;
   assign dif.next_instr = next_instr;

   bcx_decode u_dec (
      .d(dif.dec)
   );

   bcx_cmp u_cmp (
      .a(cmp_a),
      .b(cmp_b),
      .use_carry(cmp_use_c),
      .flags_in(status_in),
      .flags_out(cmp_flags)
   );

   function automatic logic [31:0] reg_read(input logic [7:0] a, input bcx_regs_t s);
      reg_read = 32'h0000_0000;
      case (a)
         `BCX_REG_CTRL: reg_read[`BCX_CTRL_RUN_BIT] = s.run;
         `BCX_REG_PROG: reg_read[PC_W-1:0] = s.prog;
         `BCX_REG_STATE: reg_read[7:0] = {s.last_op, 2'h0, s.st};
         `BCX_REG_COUNT: reg_read[15:0] = s.nops;
         default: reg_read = 32'h0000_0000;
      endcase
   endfunction

   // Fetch is only offered while running and no multi-cycle op is in flight
   assign instr_ready = q_ff.run && (q_ff.st == BCX_IDLE);
   assign accept = instr_valid && instr_ready;
   assign rd_addr = dif.rd;
   assign rr_addr = dif.rr;
   assign cmp_a = rd_data;
   assign cmp_b = (dif.op == bcx_compare_immediate_op) ? dif.imm : rr_data;
   assign cmp_use_c = (dif.op == bcx_compare_with_carry_op);

   assign addr_plus1 = q_ff.prog + {{(PC_W-1){1'b0}}, 1'b1};
   assign rel_tgt = q_ff.prog + dif.off[PC_W-1:0] + {{(PC_W-1){1'b0}}, 1'b1};
   // Skipping a two-word instruction costs one more word and one more cycle
   assign skip_tgt = q_ff.prog + (dif.two_word ? PC_W'(3) : PC_W'(2));
   assign skip_m1 = dif.two_word ? `BCX_CYC3_M1 : `BCX_CYC2_M1;
   assign reg_bit = rr_data[dif.bsel];
   assign stat_bit = status_in[dif.bsel];

   always_comb
   begin
      nxt_q = q_ff;
      nxt_q.push_v = 1'b0;
      nxt_q.pop_req = 1'b0;
      nxt_q.flg_we = 1'b0;
      nxt_q.hrdata = q_ff.hrdata;
      case (q_ff.st)
         BCX_IDLE:
         begin
            if (accept)
            begin
               nxt_q.last_op = dif.op;
               nxt_q.nops = q_ff.nops + 16'h0001;
               nxt_q.prog = addr_plus1;
               case (dif.op)
                  bcx_relative_jump_op:
                  begin
                     nxt_q.tgt = rel_tgt;
                     nxt_q.st = BCX_BUSY;
                     nxt_q.cnt = `BCX_CYC2_M1;
                     nxt_q.prog = q_ff.prog;
                  end
                  bcx_pointer_jump_op:
                  begin
                     nxt_q.tgt = zptr;
                     nxt_q.st = BCX_BUSY;
                     nxt_q.cnt = `BCX_CYC2_M1;
                     nxt_q.prog = q_ff.prog;
                  end
                  bcx_relative_call_op, bcx_pointer_call_op:
                  begin
                     // Return address goes out before the jump lands
                     nxt_q.push_v = 1'b1;
                     nxt_q.push_d = addr_plus1;
                     nxt_q.tgt = (dif.op == bcx_relative_call_op) ? rel_tgt : zptr;
                     nxt_q.st = BCX_BUSY;
                     nxt_q.cnt = `BCX_CYC3_M1;
                     nxt_q.prog = q_ff.prog;
                  end
                  bcx_subroutine_return_op, bcx_interrupt_return_op:
                  begin
                     nxt_q.pop_req = 1'b1;
                     nxt_q.st = BCX_BUSY;
                     nxt_q.cnt = `BCX_CYC4_M1;
                     nxt_q.prog = q_ff.prog;
                     if (dif.op == bcx_interrupt_return_op)
                     begin
                        nxt_q.flg_we = 1'b1;
                        nxt_q.flg = status_in;
                        nxt_q.flg[`BCX_FLAG_I] = 1'b1;
                     end
                  end
                  bcx_compare_skip_equal_op, bcx_skip_reg_bit_clear_op, bcx_skip_reg_bit_set_op:
                  begin
                     if ((dif.op == bcx_compare_skip_equal_op && rd_data == rr_data) ||
                        (dif.op == bcx_skip_reg_bit_clear_op && !reg_bit) ||
                        (dif.op == bcx_skip_reg_bit_set_op && reg_bit))
                     begin
                        nxt_q.tgt = skip_tgt;
                        nxt_q.st = BCX_BUSY;
                        nxt_q.cnt = skip_m1;
                        nxt_q.prog = q_ff.prog;
                     end
                  end
                  bcx_register_compare_op, bcx_compare_with_carry_op, bcx_compare_immediate_op:
                  begin
                     nxt_q.flg_we = 1'b1;
                     nxt_q.flg = cmp_flags;
                  end
                  bcx_branch_status_bit_set_op, bcx_branch_status_bit_clear_op:
                  begin
                     if (stat_bit == (dif.op == bcx_branch_status_bit_set_op))
                     begin
                        nxt_q.tgt = rel_tgt;
                        nxt_q.st = BCX_BUSY;
                        nxt_q.cnt = `BCX_CYC2_M1;
                        nxt_q.prog = q_ff.prog;
                     end
                  end
                  default: nxt_q.prog = addr_plus1;
               endcase
            end
         end
         BCX_BUSY:
         begin
            nxt_q.cnt = q_ff.cnt - 2'h1;
            // Stack answers in the cycle after the pop request
            nxt_q.pop_wait = q_ff.pop_req;
            if (q_ff.pop_wait)
               nxt_q.tgt = stack_data;
            if (q_ff.cnt == 2'h1)
            begin
               nxt_q.prog = q_ff.tgt;
               nxt_q.st = BCX_IDLE;
            end
         end
         default: nxt_q.st = BCX_IDLE;
      endcase

      // Bus data phase; address changes only while halted, to avoid racing a jump
      if (q_ff.hr_sel && q_ff.hr_wr)
      begin
         if (q_ff.hr_addr == `BCX_REG_CTRL)
            nxt_q.run = hwdata[`BCX_CTRL_RUN_BIT];
         if (q_ff.hr_addr == `BCX_REG_PROG && !q_ff.run && q_ff.st == BCX_IDLE)
            nxt_q.prog = hwdata[PC_W-1:0];
      end
      // Bus address phase; read data is captured here and held through the data phase
      nxt_q.hr_sel = hsel && htrans[1] && hready;
      if (hsel && htrans[1] && hready)
      begin
         nxt_q.hr_wr = hwrite;
         nxt_q.hr_addr = {haddr[7:2], 2'b00};
         if (!hwrite)
            nxt_q.hrdata = reg_read({haddr[7:2], 2'b00}, q_ff);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q_ff <= '0;
         q_ff.st <= BCX_IDLE;
         q_ff.run <= `BCX_CTRL_RST;
         q_ff.last_op <= bcx_other_op;
      end
      else
         q_ff <= nxt_q;
   end

   // Zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q_ff.hrdata;
   assign program_counter = q_ff.prog;
   assign push_valid = q_ff.push_v;
   assign push_data = q_ff.push_d;
   assign pop_req = q_ff.pop_req;
   assign flags_we = q_ff.flg_we;
   assign flags_out = q_ff.flg;
   assign last_op = q_ff.last_op;

   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_busy2;
      !instr_ready ##1 instr_ready;
   endsequence
   sequence s_busy3;
      !instr_ready [*2] ##1 instr_ready;
   endsequence

   property p_rel_jump;
      accept && dif.op == bcx_relative_jump_op |=> s_busy2 and
         (##1 program_counter == $past(rel_tgt, 2));
   endproperty
   a_rel_jump: assert property (p_rel_jump) else $error("relative jump wrong");

   property p_ptr_jump;
      accept && dif.op == bcx_pointer_jump_op |=> ##1 program_counter == $past(zptr, 2);
   endproperty
   a_ptr_jump: assert property (p_ptr_jump) else $error("pointer jump wrong");

   property p_rel_call;
      accept && dif.op == bcx_relative_call_op |=> push_valid &&
         push_data == $past(addr_plus1) ##0 s_busy3 ##0 program_counter == $past(rel_tgt, 3);
   endproperty
   a_rel_call: assert property (p_rel_call) else $error("relative call wrong");

   property p_ptr_call;
      accept && dif.op == bcx_pointer_call_op |=> push_valid ##0 s_busy3;
   endproperty
   a_ptr_call: assert property (p_ptr_call) else $error("pointer call wrong");

   property p_sub_ret;
      accept && dif.op == bcx_subroutine_return_op |=> pop_req && !flags_we ##1
         !instr_ready [*2] ##1 instr_ready && program_counter == $past(stack_data, 2);
   endproperty
   a_sub_ret: assert property (p_sub_ret) else $error("return wrong");

   property p_irq_ret;
      accept && dif.op == bcx_interrupt_return_op |=> flags_we && flags_out[`BCX_FLAG_I] &&
         pop_req;
   endproperty
   a_irq_ret: assert property (p_irq_ret) else $error("interrupt return wrong");

   property p_skip_eq;
      accept && dif.op == bcx_compare_skip_equal_op && rd_data == rr_data && !dif.two_word
         |=> !flags_we ##1 program_counter == $past(skip_tgt, 2) && instr_ready;
   endproperty
   a_skip_eq: assert property (p_skip_eq) else $error("equal skip wrong");

   property p_cmp;
      accept && dif.op == bcx_register_compare_op |=> flags_we && instr_ready &&
         flags_out[`BCX_FLAG_Z] == ($past(rd_data) == $past(rr_data)) &&
         flags_out[`BCX_FLAG_C] == ($past(rd_data) < $past(rr_data));
   endproperty
   a_cmp: assert property (p_cmp) else $error("compare flags wrong");

   property p_bit_clr_skip;
      accept && dif.op == bcx_skip_reg_bit_clear_op && !reg_bit && dif.two_word
         |=> s_busy3 ##0 program_counter == $past(skip_tgt, 3);
   endproperty
   a_bit_clr_skip: assert property (p_bit_clr_skip) else $error("bit skip wrong");

   property p_br_fall;
      accept && dif.op == bcx_branch_status_bit_set_op && !stat_bit
         |=> instr_ready && program_counter == $past(addr_plus1);
   endproperty
   a_br_fall: assert property (p_br_fall) else $error("branch fall-through wrong");

   property p_brc_taken;
      accept && dif.op == bcx_branch_status_bit_clear_op && !stat_bit
         |=> s_busy2 ##0 program_counter == $past(rel_tgt, 2);
   endproperty
   a_brc_taken: assert property (p_brc_taken) else $error("branch taken wrong");
endmodule // bcx_exec_unit

// file: hw/bcx_pkg.sv
// Types shared by the branch/compare execution unit
package bcx_pkg;
   typedef enum logic [3:0] {
      bcx_other_op = 4'h0,
      bcx_relative_jump_op = 4'h1,
      bcx_pointer_jump_op = 4'h2,
      bcx_relative_call_op = 4'h3,
      bcx_pointer_call_op = 4'h4,
      bcx_subroutine_return_op = 4'h5,
      bcx_interrupt_return_op = 4'h6,
      bcx_compare_skip_equal_op = 4'h7,
      bcx_register_compare_op = 4'h8,
      bcx_compare_with_carry_op = 4'h9,
      bcx_compare_immediate_op = 4'hA,
      bcx_skip_reg_bit_clear_op = 4'hB,
      bcx_skip_reg_bit_set_op = 4'hC,
      bcx_branch_status_bit_set_op = 4'hD,
      bcx_branch_status_bit_clear_op = 4'hE
   } bcx_op_t;

   typedef enum logic [1:0] {
      BCX_IDLE = 2'b01,
      BCX_BUSY = 2'b10
   } bcx_state_t;
endpackage

// file: tb/bcx_partner.sv
// Far-side model: register file read port and return-address stack
`timescale 1ns/1ps
module bcx_partner #(
   parameter int PC_W = 16
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Register file
   input wire logic [4:0] rd_addr,
   input wire logic [4:0] rr_addr,
   output logic [7:0] rd_data,
   output logic [7:0] rr_data,
   // Stack
   input wire logic push_valid,
   input wire logic [PC_W-1:0] push_data,
   input wire logic pop_req,
   output logic [PC_W-1:0] stack_data
);
   logic [PC_W-1:0] mem [0:15];
   logic [3:0] sp;
   logic shown;
   logic [PC_W-1:0] word;
   // Each register simply holds its own index
   assign rd_data = {3'h0, rd_addr};
   assign rr_data = {3'h0, rr_addr};
   // Outside the one valid cycle the bus shows the inverse, so a late sample is caught
   assign stack_data = shown ? word : ~word;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sp <= 4'h0;
         shown <= 1'b0;
         word <= '0;
      end
      else
      begin
         shown <= pop_req;
         if (push_valid)
         begin
            mem[sp] <= push_data;
            sp <= sp + 4'h1;
         end
         else if (pop_req)
         begin
            word <= mem[sp - 4'h1];
            sp <= sp - 4'h1;
         end
      end
   end
endmodule // bcx_partner

// file: tb/testbench.sv
// Self-checking bench for the branch/compare execution unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench;
   import bcx_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, instr_valid = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0;
   logic [15:0] instr = 0, next_instr = 0, program_counter, zptr = 16'h0100, push_data, stack_data;
   logic [7:0] status_in = 0, rd_data, rr_data, flags_out;
   logic [4:0] rd_addr, rr_addr;
   logic hreadyout, hresp, instr_ready, flags_we, push_valid, pop_req;
   bcx_op_t last_op;
   int failures = 0, comparisons = 0;
   always #10 hclk = ~hclk;
   bcx_exec_unit #(.PC_W(16)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instr_valid(instr_valid),
      .instr(instr), .next_instr(next_instr), .instr_ready(instr_ready),
      .program_counter(program_counter), .rd_addr(rd_addr), .rr_addr(rr_addr),
      .rd_data(rd_data), .rr_data(rr_data), .status_in(status_in), .zptr(zptr),
      .flags_we(flags_we), .flags_out(flags_out), .last_op(last_op), .push_valid(push_valid),
      .push_data(push_data), .pop_req(pop_req), .stack_data(stack_data));
   bcx_partner #(.PC_W(16)) far (.hclk(hclk), .hresetn(hresetn), .rd_addr(rd_addr),
      .rr_addr(rr_addr), .rd_data(rd_data), .rr_data(rr_data), .push_valid(push_valid),
      .push_data(push_data), .pop_req(pop_req), .stack_data(stack_data));
   task end_sim;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Bounded wait for hready at a rising edge
   task wait_rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         failures++;
         end_sim();
      end
   endtask
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      `CHK("hresp", 1'b0, hresp)
   endtask
   // Issue one instruction, check flag pulse, cycle count and new program counter
   task exec(input logic [15:0] iw, input logic [15:0] nw, input logic [7:0] st, input int cyc,
      input logic [15:0] pc_e, input logic fchk, input logic [7:0] fl_e);
      int n;
      @(posedge hclk);
      instr <= iw;
      next_instr <= nw;
      status_in <= st;
      instr_valid <= 1'b1;
      @(posedge hclk);
      instr_valid <= 1'b0;
      #1;
      `CHK("flags_we", fchk, flags_we)
      if (fchk)
         `CHK("flags_out", fl_e, flags_out)
      n = 1;
      while (instr_ready !== 1'b1 && n < 9)
      begin
         @(posedge hclk);
         #1;
         n++;
      end
      `CHK("cycles", cyc, n)
      `CHK("program_counter", pc_e, program_counter)
   endtask
   initial
   begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      exec(16'hC005, 0, 0, 2, 16'h0006, 0, 0);
      exec(16'hCFFE, 0, 0, 2, 16'h0005, 0, 0);
      exec(16'h9409, 0, 0, 2, 16'h0100, 0, 0);
      exec(16'hD010, 0, 0, 3, 16'h0111, 0, 0);
      exec(16'h9509, 0, 0, 3, 16'h0100, 0, 0);
      exec(16'h9508, 0, 0, 4, 16'h0112, 0, 0);
      exec(16'h9518, 0, 8'h02, 4, 16'h0101, 1, 8'h82);
      $display("test control flow done");
      exec(16'h1011, 0, 0, 2, 16'h0103, 0, 0);
      exec(16'h1012, 0, 0, 1, 16'h0104, 0, 0);
      exec(16'h1033, 16'h940C, 0, 3, 16'h0107, 0, 0);
      exec(16'h1435, 0, 0, 1, 16'h0108, 1, 8'h25);
      exec(16'h0422, 0, 8'h01, 1, 16'h0109, 1, 8'h25);
      exec(16'h3100, 0, 0, 1, 16'h010A, 1, 8'h02);
      exec(16'hFC40, 0, 0, 2, 16'h010C, 0, 0);
      exec(16'hFE42, 16'h9000, 0, 3, 16'h010F, 0, 0);
      exec(16'hFE40, 0, 0, 1, 16'h0110, 0, 0);
      exec(16'hF019, 0, 8'h02, 2, 16'h0114, 0, 0);
      exec(16'hF019, 0, 0, 1, 16'h0115, 0, 0);
      exec(16'hF7E0, 0, 0, 2, 16'h0112, 0, 0);
      exec(16'hF7E0, 0, 8'h01, 1, 16'h0113, 0, 0);
      `CHK("last_op", bcx_branch_status_bit_clear_op, last_op)
      $display("test compare and skip done");
      ahb(0, 32'h0C, 0);
      `CHK("COUNT", 32'h14, rd)
      ahb(0, 32'h08, 0);
      `CHK("STATE", 32'hE1, rd)
      ahb(0, 32'h10, 0);
      `CHK("unmapped", 32'h0, rd)
      ahb(1, 32'h04, 32'h40);
      ahb(0, 32'h04, 0);
      `CHK("PROG running", 32'h113, rd)
      ahb(1, 32'h00, 32'h0);
      ahb(1, 32'h04, 32'h40);
      ahb(0, 32'h04, 0);
      `CHK("PROG halted", 32'h40, rd)
      `CHK("halted ready", 1'b0, instr_ready)
      ahb(1, 32'h00, 32'h1);
      ahb(0, 32'h00, 0);
      `CHK("CTRL", 32'h1, rd)
      exec(16'hC000, 0, 0, 2, 16'h0041, 0, 0);
      exec(16'hFC40, 16'h9000, 0, 3, 16'h0044, 0, 0);
      $display("test registers done");
      end_sim();
   end
   initial
   begin
      #200000;
      failures++;
      end_sim();
   end
endmodule // testbench
